// ---- rtl/mcff_pkg.sv ----
// Constants and types for the mode command frame filter.
// Assumes a single 100 MHz pclk domain and an APB register bus.
package mcff_pkg;

    // Register byte offsets
    localparam logic [7:0] MCFF_CMD_OFF     = 8'h00; // Write command, read semaphore
    localparam logic [7:0] MCFF_MODE_OFF    = 8'h04; // Current mode bits
    localparam logic [7:0] MCFF_TSADDR_OFF  = 8'h08; // Station address
    localparam logic [7:0] MCFF_IAMASK_OFF  = 8'h0c; // Individual address mask
    localparam logic [7:0] MCFF_GAMASK_OFF  = 8'h10; // Group address mask
    localparam logic [7:0] MCFF_RESULT_OFF  = 8'h14; // Last frame verdict
    localparam logic [7:0] MCFF_TKPASS_OFF  = 8'h18; // Token pass counter
    localparam logic [7:0] MCFF_TKHEARD_OFF = 8'h1c; // Token heard counter
    localparam logic [7:0] MCFF_OTHER_OFF   = 8'h20; // Other statistics counter
    localparam logic [7:0] MCFF_RWRPEND_OFF = 8'h24; // Host response pending, write 1 for ready

    // Command decode patterns
    localparam logic [3:0] MCFF_MODE1_CODE = 4'h2;  // Bits 7..4
    localparam logic [2:0] MCFF_MODE2_CODE = 3'h2;  // Bits 7..5

    // Semaphore values
    localparam logic [7:0] MCFF_SEM_ACCEPT = 8'hfe;
    localparam logic [7:0] MCFF_SEM_RESET  = 8'hff;

    // Mode field positions inside the mode register
    localparam int MCFF_PREDEF_BIT  = 0;
    localparam int MCFF_LIMSTAT_BIT = 1;
    localparam int MCFF_COPYALL_BIT = 2;
    localparam int MCFF_UNDEFFC_BIT = 3;
    localparam int MCFF_SRCRT_BIT   = 4;
    localparam int MCFF_BRDLY_BIT   = 5;
    localparam int MCFF_LIMBC_BIT   = 6;
    localparam int MCFF_INRING_BIT  = 7;
    localparam int MCFF_LOWBR_BIT   = 8;
    localparam int MCFF_HALTEN_BIT  = 9;

    // Reset value: all zero except the DMA burst limit enable
    localparam logic [9:0] MCFF_MODE_RESET = 10'h200;

    // Frame class codes presented at the frame port
    localparam logic [1:0] MCFF_FC_DATA    = 2'h0;
    localparam logic [1:0] MCFF_FC_CONTROL = 2'h1;
    localparam logic [1:0] MCFF_FC_UNDEF   = 2'h2;

    // Priority assigned in copy-all mode
    localparam logic [2:0] MCFF_COPYALL_PRIO = 3'h6;

    // Bridge delay: one slot time, figure in ns
    localparam int MCFF_SLOT_NS    = 5120;
    localparam int MCFF_CLK_NS     = 10;
    localparam int MCFF_SLOT_CYC   = (MCFF_SLOT_NS + MCFF_CLK_NS - 1) / MCFF_CLK_NS;

    // Verdict register fields
    localparam int MCFF_RES_ACCEPT = 0;
    localparam int MCFF_RES_NOISE  = 1;
    localparam int MCFF_RES_ROUTED = 2;

    typedef enum logic [2:0] {
        MCFF_TX_IDLE = 3'b001,
        MCFF_TX_WAIT = 3'b010,
        MCFF_TX_GO   = 3'b100
    } mcff_tx_t;

endpackage : mcff_pkg

// ---- rtl/mcff_delay.sv ----
// Bridge transmit delay timer: holds back a control or response frame.
// Assumes requests arrive as one-cycle pulses from the frame filter.
`timescale 1ns/10ps
`default_nettype none
module mcff_delay #(
    parameter int SLOT_CYC = 512
) (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Control
    input  wire logic enable,
    input  wire logic data_sent,
    input  wire logic send_req,
    // Result
    output logic      send_go,
    output logic      waiting
);
    import mcff_pkg::*;

    mcff_tx_t    state_q, state_d;
    logic [15:0] cnt_q, cnt_d;
    logic        armed_q;

    wire need_wait = enable && armed_q;
    wire cnt_done  = (cnt_q == 16'h0001);

    // Next state for the slot wait
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            MCFF_TX_IDLE: begin
                if (send_req && need_wait) begin
                    state_d = MCFF_TX_WAIT;
                    cnt_d   = SLOT_CYC[15:0];
                end else if (send_req) begin
                    state_d = MCFF_TX_GO;
                end
            end
            MCFF_TX_WAIT: begin
                cnt_d = cnt_q - 16'h0001;
                if (cnt_done) begin
                    state_d = MCFF_TX_GO;
                end
            end
            MCFF_TX_GO: begin
                state_d = MCFF_TX_IDLE;
            end
            default: state_d = MCFF_TX_IDLE;
        endcase
    end

    // State, counter and the data-frame-sent marker
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= MCFF_TX_IDLE;
            cnt_q   <= 16'h0000;
            armed_q <= 1'b0;
            send_go <= 1'b0;
            waiting <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            armed_q <= data_sent ? 1'b1 : (state_d == MCFF_TX_GO ? 1'b0 : armed_q);
            send_go <= (state_d == MCFF_TX_GO);
            waiting <= (state_d == MCFF_TX_WAIT);
        end
    end

    wait_len_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == MCFF_TX_IDLE && send_req && need_wait) |-> ##1 waiting[*8])
        else $error("bridge delay wait too short");

endmodule : mcff_delay
`default_nettype wire

// ---- rtl/mcff_top.sv ----
// Mode command frame filter: decodes mode commands 1 and 2 and filters frames.
// Assumes an APB master and a frame source that presents header fields with a start pulse.
//
// Notes on behaviour
// - After reset all mode bits are zero except the burst limit enable.
// - Command 1 is 0010xxxx, command 2 is 010xxxxx; low bits carry flags.
// - Undefined frame control accepted as data when flag set, else noise.
// - Copy-all stores every accepted frame as priority six data.
// - Limited statistics freezes token pass and heard counters only.
// - Predefined response sends prepared response at once on request frame.
// - Otherwise host is notified and must signal response ready.
// - Lower bridge inverts individual address masked comparison.
// - Lower bridge accepts group frames not matching group mask; broadcast unchanged.
// - Source routing overrides lower bridge when both are set.
// - Ring membership flag chooses steady ring state; set from table value.
// - Limited broadcast routed frames accepted only when flag is set.
// - Bridge delay waits a slot after data before token or request frame.
// - Control frame with source address bit zero set is noise.
// - Routed frame without routing recognition is filtered on destination only.
// - With routing, accept on destination match or onward route.
// - Source address bit zero clear means ordinary frame.
// - Any accepted command sets the semaphore to fe.
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
module mcff_top #(
    parameter int ADDR_W   = 48,
    parameter int SLOT_CYC = mcff_pkg::MCFF_SLOT_CYC
) (
    // APB
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Initial ring membership value from the table
    input  wire logic              ring_init_load,
    input  wire logic              ring_init_value,
    // Received frame header
    input  wire logic              frame_start,
    input  wire logic [1:0]        frame_class,
    input  wire logic [2:0]        frame_prio,
    input  wire logic [ADDR_W-1:0] dest_addr,
    input  wire logic [ADDR_W-1:0] src_addr,
    input  wire logic              dest_group,
    input  wire logic              dest_broadcast,
    input  wire logic              frame_is_rwr,
    input  wire logic              route_onward,
    input  wire logic              route_broadcast,
    input  wire logic              route_limited,
    input  wire logic              token_pass_evt,
    input  wire logic              token_heard_evt,
    input  wire logic              other_stat_evt,
    // Transmit side
    input  wire logic              data_frame_sent,
    input  wire logic              ctrl_send_req,
    // Frame verdict
    output logic                   frame_store,
    output logic                   frame_noise,
    output logic [2:0]             store_prio,
    output logic                   routing_in_data,
    output logic                   send_prepared,
    output logic                   notify_host,
    output logic                   ctrl_send_go,
    output logic                   ring_membership_wanted,
    output logic                   dma_burst_limit_enable
);
    import mcff_pkg::*;

    localparam logic [2:0] PRIO_ZERO = 3'h0;

    logic [9:0]        mode_q;
    logic [9:0]        fmode_q;
    logic [7:0]        sem_q;
    logic [ADDR_W-1:0] ts_q, ia_q, ga_q;
    logic [31:0]       tkpass_q, tkheard_q, other_q;
    logic [3:0]        result_q;
    logic              rwr_pend_q;
    logic              delay_wait;
    logic              delay_go;

    // APB decode
    wire       wr_en   = psel && penable && pwrite;
    wire [7:0] cmd     = pwdata[7:0];
    wire       cmd_wr  = wr_en && (paddr == MCFF_CMD_OFF);
    wire       is_m1   = cmd[7:4] == MCFF_MODE1_CODE;
    wire       is_m2   = cmd[7:5] == MCFF_MODE2_CODE;
    wire       known   = (paddr == MCFF_CMD_OFF) || (paddr == MCFF_MODE_OFF) ||
                         (paddr == MCFF_TSADDR_OFF) || (paddr == MCFF_IAMASK_OFF) ||
                         (paddr == MCFF_GAMASK_OFF) || (paddr == MCFF_RESULT_OFF) ||
                         (paddr == MCFF_TKPASS_OFF) || (paddr == MCFF_TKHEARD_OFF) ||
                         (paddr == MCFF_OTHER_OFF) || (paddr == MCFF_RWRPEND_OFF);

    // Read multiplexer
    function automatic logic [31:0] low32(input logic [ADDR_W-1:0] v);
        low32 = v[31:0];
    endfunction
    logic [31:0] rd_mux;
    always_comb begin
        if (paddr == MCFF_CMD_OFF)          rd_mux = {24'h0, sem_q};
        else if (paddr == MCFF_MODE_OFF)    rd_mux = {22'h0, mode_q};
        else if (paddr == MCFF_TSADDR_OFF)  rd_mux = low32(ts_q);
        else if (paddr == MCFF_IAMASK_OFF)  rd_mux = low32(ia_q);
        else if (paddr == MCFF_GAMASK_OFF)  rd_mux = low32(ga_q);
        else if (paddr == MCFF_RESULT_OFF)  rd_mux = {28'h0, result_q};
        else if (paddr == MCFF_TKPASS_OFF)  rd_mux = tkpass_q;
        else if (paddr == MCFF_TKHEARD_OFF) rd_mux = tkheard_q;
        else if (paddr == MCFF_OTHER_OFF)   rd_mux = other_q;
        else if (paddr == MCFF_RWRPEND_OFF) rd_mux = {31'h0, rwr_pend_q};
        else                                rd_mux = 32'h0;
    end

    // Next mode bits from a command byte
    logic [9:0] mode_d;
    always_comb begin
        mode_d = mode_q;
        if (cmd_wr && is_m1) begin
            mode_d[MCFF_UNDEFFC_BIT] = cmd[3];
            mode_d[MCFF_COPYALL_BIT] = cmd[2];
            mode_d[MCFF_LIMSTAT_BIT] = cmd[1];
            mode_d[MCFF_PREDEF_BIT]  = cmd[0];
        end else if (cmd_wr && is_m2) begin
            mode_d[MCFF_LOWBR_BIT]   = cmd[4];
            mode_d[MCFF_INRING_BIT]  = cmd[3];
            mode_d[MCFF_LIMBC_BIT]   = cmd[2];
            mode_d[MCFF_BRDLY_BIT]   = cmd[1];
            mode_d[MCFF_SRCRT_BIT]   = cmd[0];
        end else if (ring_init_load) begin
            mode_d[MCFF_INRING_BIT]  = ring_init_value;
        end
    end

    // Filter modes: a starting frame sees every command accepted before it
    wire [9:0] fm = frame_start ? mode_q : fmode_q;

    wire srcrt   = fm[MCFF_SRCRT_BIT];
    wire lowbr   = fm[MCFF_LOWBR_BIT] && !srcrt;
    wire ind_eq  = (dest_addr & ia_q) == (ts_q & ia_q);
    wire grp_eq  = (dest_addr & ga_q) == dest_addr;
    wire ind_ok  = lowbr ? !ind_eq : ind_eq;
    wire grp_ok  = lowbr ? !grp_eq : grp_eq;
    wire da_ok   = dest_broadcast || (dest_group ? grp_ok : ind_ok);
    wire sa_rt   = src_addr[0];
    wire is_ctrl = frame_class == MCFF_FC_CONTROL;
    wire is_udef = frame_class == MCFF_FC_UNDEF;
    wire rt_bc   = !route_broadcast || !route_limited || fm[MCFF_LIMBC_BIT];
    wire rt_ok   = srcrt && sa_rt && !is_ctrl && rt_bc && (route_onward || route_broadcast);
    wire noise   = (is_ctrl && sa_rt) || (is_udef && !fm[MCFF_UNDEFFC_BIT]);
    wire accept  = !noise && (da_ok || rt_ok);
    wire store   = accept && (!is_ctrl || fm[MCFF_COPYALL_BIT]);
    wire [2:0] prio = (fm[MCFF_COPYALL_BIT] || is_udef) ? MCFF_COPYALL_PRIO : frame_prio;
    wire rwr_ok  = store && frame_is_rwr && !is_ctrl;

    // Registers, semaphore and mode state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q     <= MCFF_MODE_RESET;
            sem_q      <= MCFF_SEM_RESET;
            ts_q       <= '0;
            ia_q       <= '0;
            ga_q       <= '0;
            pready     <= 1'b0;
            pslverr    <= 1'b0;
            prdata     <= 32'h0;
        end else begin
            mode_q  <= mode_d;
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !known;
            prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h0;
            if (cmd_wr && pready) sem_q <= MCFF_SEM_ACCEPT;
            if (wr_en && pready && paddr == MCFF_TSADDR_OFF) ts_q <= ADDR_W'(pwdata);
            if (wr_en && pready && paddr == MCFF_IAMASK_OFF) ia_q <= ADDR_W'(pwdata);
            if (wr_en && pready && paddr == MCFF_GAMASK_OFF) ga_q <= ADDR_W'(pwdata);
        end
    end

    // Frame verdict and statistics
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fmode_q         <= MCFF_MODE_RESET;
            result_q        <= 4'h0;
            frame_store     <= 1'b0;
            frame_noise     <= 1'b0;
            store_prio      <= PRIO_ZERO;
            routing_in_data <= 1'b0;
            send_prepared   <= 1'b0;
            notify_host     <= 1'b0;
            rwr_pend_q      <= 1'b0;
            tkpass_q        <= 32'h0;
            tkheard_q       <= 32'h0;
            other_q         <= 32'h0;
        end else begin
            if (frame_start) fmode_q <= mode_q;
            frame_store     <= frame_start && store;
            frame_noise     <= frame_start && noise;
            store_prio      <= frame_start ? prio : PRIO_ZERO;
            routing_in_data <= frame_start && store && sa_rt && !is_ctrl;
            send_prepared   <= frame_start && rwr_ok && fm[MCFF_PREDEF_BIT];
            notify_host     <= frame_start && rwr_ok && !fm[MCFF_PREDEF_BIT];
            if (frame_start) result_q <= {1'b0, sa_rt && rt_ok, noise, store};
            // New request sets pending and wins over host clear
            if (frame_start && rwr_ok && !fm[MCFF_PREDEF_BIT]) rwr_pend_q <= 1'b1;
            else if (wr_en && pready && paddr == MCFF_RWRPEND_OFF && pwdata[0]) rwr_pend_q <= 1'b0;
            if (token_pass_evt && !mode_q[MCFF_LIMSTAT_BIT]) tkpass_q <= tkpass_q + 32'h1;
            if (token_heard_evt && !mode_q[MCFF_LIMSTAT_BIT]) tkheard_q <= tkheard_q + 32'h1;
            if (other_stat_evt) other_q <= other_q + 32'h1;
        end
    end

    // Mode pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ring_membership_wanted <= 1'b0;
            dma_burst_limit_enable <= 1'b1;
            ctrl_send_go           <= 1'b0;
        end else begin
            ring_membership_wanted <= mode_q[MCFF_INRING_BIT];
            dma_burst_limit_enable <= mode_q[MCFF_HALTEN_BIT];
            ctrl_send_go           <= delay_go;
        end
    end

    // Slot delay ahead of token or request frames
    mcff_delay #(
        .SLOT_CYC (SLOT_CYC)
    ) u_delay (
        .pclk      (pclk),
        .presetn   (presetn),
        .enable    (mode_q[MCFF_BRDLY_BIT]),
        .data_sent (data_frame_sent),
        .send_req  (ctrl_send_req),
        .send_go   (delay_go),
        .waiting   (delay_wait)
    );

    // Checks on the semaphore, command decode, verdicts and mode pins
    sem_accept_a: assert property (@(posedge pclk) disable iff (!presetn)
        (cmd_wr && pready) |=> (sem_q == MCFF_SEM_ACCEPT))
        else $error("semaphore not fe after command");

    mode1_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        (cmd_wr && is_m1) |=> (mode_q[3:0] == $past(cmd[3:0])))
        else $error("mode 1 flags not loaded");

    mode2_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        (cmd_wr && is_m2) |=> (mode_q[MCFF_LOWBR_BIT] == $past(cmd[4]) && mode_q[MCFF_SRCRT_BIT] == $past(cmd[0])))
        else $error("mode 2 flags not loaded");

    noise_ctrl_a: assert property (@(posedge pclk) disable iff (!presetn)
        (frame_start && is_ctrl && sa_rt) |=> (frame_noise && !frame_store))
        else $error("routed control frame not noise");

    undef_fc_a: assert property (@(posedge pclk) disable iff (!presetn)
        (frame_start && is_udef && !fm[MCFF_UNDEFFC_BIT]) |=> !frame_store)
        else $error("undefined frame stored");

    copy_prio_a: assert property (@(posedge pclk) disable iff (!presetn)
        (frame_start && store && fm[MCFF_COPYALL_BIT]) |=> (frame_store && store_prio == 3'h6))
        else $error("copy-all priority wrong");

    tkpass_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_q[MCFF_LIMSTAT_BIT] && !cmd_wr) |=> $stable(tkpass_q))
        else $error("token pass counter moved");

    rwr_split_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(send_prepared && notify_host))
        else $error("both response paths active");

    lowbr_inv_a: assert property (@(posedge pclk) disable iff (!presetn)
        (frame_start && !noise && !dest_group && !dest_broadcast && !rt_ok && lowbr && ind_eq) |=> !frame_store)
        else $error("lower bridge accepted matching address");

    reset_mode_a: assert property (@(posedge pclk)
        !presetn |-> (mode_q == MCFF_MODE_RESET))
        else $error("mode not at reset value");

    live_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
        (frame_start && rwr_ok) |=> (send_prepared == $past(mode_q[MCFF_PREDEF_BIT])))
        else $error("frame used stale modes");

    rwr_pend_a: assert property (@(posedge pclk) disable iff (!presetn)
        notify_host |-> rwr_pend_q)
        else $error("response pending not set");

    ring_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ring_init_load && !cmd_wr) |=> ##1 (ring_membership_wanted == $past(ring_init_value, 2)))
        else $error("ring membership pin wrong");

    bad_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !known) |=> pslverr)
        else $error("unmapped address not flagged");

endmodule : mcff_top
`default_nettype wire

// ---- testbench/mcff_medium.sv ----
// Token bus medium model: presents received frame headers to the filter.
// Assumes the bench calls send from one process, one frame at a time.
`timescale 1ns/10ps
`default_nettype none
module mcff_medium (
    // Clock
    input  wire logic        pclk,
    // Frame header
    output logic             frame_start,
    output logic [1:0]       frame_class,
    output logic [2:0]       frame_prio,
    output logic [47:0]      dest_addr,
    output logic [47:0]      src_addr,
    output logic [5:0]       flags
);
    // Quiet line at time zero
    initial begin
        frame_start = 1'h0;
        frame_class = 2'h3;
        frame_prio  = 3'h7;
        dest_addr   = '1;
        src_addr    = '1;
        flags       = 6'h3f;
    end
    // One header for one cycle, then scrambled fields so stale values never match
    task automatic send(input logic [1:0] c, input logic [2:0] p, input logic [47:0] d, input logic [47:0] s,
                        input logic [5:0] f);
        @(posedge pclk);
        frame_start <= 1'h1;
        frame_class <= c;
        frame_prio  <= p;
        dest_addr   <= d;
        src_addr    <= s;
        flags       <= f;
        @(posedge pclk);
        frame_start <= 1'h0;
        frame_class <= ~c;
        frame_prio  <= ~p;
        dest_addr   <= ~d;
        src_addr    <= ~s;
        flags       <= ~f;
    endtask : send
endmodule : mcff_medium
`default_nettype wire

// ---- testbench/test_mode_command_frame_filter.sv ----
// Testbench for the mode command frame filter: APB commands, frame verdicts, statistics, delay.
// Assumes the medium model presents headers; the bench acts as the APB host.
`timescale 1ns/10ps
`default_nettype none
module test_mode_command_frame_filter;
    import mcff_pkg::*;
    typedef struct packed {
        logic [7:0] m1, m2;
        logic [1:0] c;
        logic [31:0] d;
        logic s;
        logic [5:0] f;
        logic [4:0] v, k;
    } mcff_case_t;
    logic        pclk = 1'h0, presetn = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, rl = 1'h0, rv = 1'h0, tp = 1'h0, th = 1'h0, os = 1'h0, ds = 1'h0, cr = 1'h0;
    logic        fs, st, nz, rd_f, sp, nh, cg, rw, dm;
    logic [1:0]  fc;
    logic [2:0]  fp, sprio;
    logic [47:0] da, sa;
    logic [5:0]  fl;
    int          n_errors = 0, check_count = 0;
    // Clock
    always #5 pclk = ~pclk;
    // Far side and device
    mcff_medium m (.pclk(pclk), .frame_start(fs), .frame_class(fc), .frame_prio(fp), .dest_addr(da),
                   .src_addr(sa), .flags(fl));
    mcff_top #(.SLOT_CYC(8)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ring_init_load(rl), .ring_init_value(rv), .frame_start(fs), .frame_class(fc), .frame_prio(fp),
        .dest_addr(da), .src_addr(sa), .dest_group(fl[5]), .dest_broadcast(fl[4]), .frame_is_rwr(fl[3]),
        .route_onward(fl[2]), .route_broadcast(fl[1]), .route_limited(fl[0]), .token_pass_evt(tp),
        .token_heard_evt(th), .other_stat_evt(os), .data_frame_sent(ds), .ctrl_send_req(cr),
        .frame_store(st), .frame_noise(nz), .store_prio(sprio), .routing_in_data(rd_f), .send_prepared(sp),
        .notify_host(nh), .ctrl_send_go(cg), .ring_membership_wanted(rw), .dma_burst_limit_enable(dm));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // APB transfer: hold the request until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'h1, a, d, r, e);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'h0, a, 32'h0, r, e);
    endtask : rd
    task automatic meas(output int n);
        @(posedge pclk);
        cr <= 1'h1;
        @(posedge pclk);
        cr <= 1'h0;
        n = 0;
        while (cg !== 1'h1 && n < 40) begin
            @(posedge pclk);
            n++;
        end
    endtask : meas
    task automatic t_reset;
        logic [31:0] r;
        rd(MCFF_MODE_OFF, r);
        chk(r, 32'h200);
        rd(MCFF_CMD_OFF, r);
        chk(r, {24'h0, MCFF_SEM_RESET});
        chk({31'h0, dm}, 32'h1);
        $display("test reset done");
    endtask : t_reset
    task automatic t_cmds;
        logic [31:0] r;
        logic e;
        wr(MCFF_CMD_OFF, 32'h2f);
        rd(MCFF_CMD_OFF, r);
        chk(r, 32'hfe);
        rd(MCFF_MODE_OFF, r);
        chk(r, 32'h20f);
        wr(MCFF_CMD_OFF, 32'h5f);
        wr(MCFF_CMD_OFF, 32'hf0);
        rd(MCFF_MODE_OFF, r);
        chk(r, 32'h3ff);
        chk({31'h0, rw}, 32'h1);
        wr(MCFF_CMD_OFF, 32'h20);
        wr(MCFF_CMD_OFF, 32'h40);
        @(posedge pclk);
        rl <= 1'h1;
        rv <= 1'h1;
        @(posedge pclk);
        rl <= 1'h0;
        rd(MCFF_MODE_OFF, r);
        chk(r, 32'h280);
        apb(1'h1, 8'h40, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        $display("test commands done");
    endtask : t_cmds
    // Verdict bits: store, noise, routed, prepared, notify; k masks the bits judged
    task automatic t_filter;
        logic [4:0] v;
        logic [31:0] r;
        mcff_case_t tab [15] = '{
            '{8'h20, 8'h40, 2'h2, 32'h1234, 1'h0, 6'h00, 5'h08, 5'h18},
            '{8'h28, 8'h40, 2'h2, 32'h1234, 1'h0, 6'h00, 5'h10, 5'h18},
            '{8'h24, 8'h40, 2'h1, 32'h1234, 1'h0, 6'h00, 5'h10, 5'h10},
            '{8'h21, 8'h40, 2'h0, 32'h1234, 1'h0, 6'h08, 5'h02, 5'h03},
            '{8'h20, 8'h40, 2'h0, 32'h1234, 1'h0, 6'h08, 5'h01, 5'h03},
            '{8'h20, 8'h50, 2'h0, 32'h5678, 1'h0, 6'h00, 5'h10, 5'h10},
            '{8'h20, 8'h40, 2'h0, 32'h5678, 1'h0, 6'h00, 5'h00, 5'h10},
            '{8'h20, 8'h51, 2'h0, 32'h5678, 1'h0, 6'h00, 5'h00, 5'h10},
            '{8'h20, 8'h50, 2'h0, 32'hff0000, 1'h0, 6'h20, 5'h10, 5'h10},
            '{8'h20, 8'h40, 2'h1, 32'h1234, 1'h1, 6'h00, 5'h08, 5'h18},
            '{8'h20, 8'h41, 2'h0, 32'h5678, 1'h1, 6'h04, 5'h14, 5'h14},
            '{8'h20, 8'h40, 2'h0, 32'h1234, 1'h1, 6'h00, 5'h14, 5'h14},
            '{8'h20, 8'h41, 2'h0, 32'h5678, 1'h1, 6'h03, 5'h00, 5'h10},
            '{8'h20, 8'h45, 2'h0, 32'h5678, 1'h1, 6'h03, 5'h10, 5'h10},
            '{8'h20, 8'h41, 2'h0, 32'h1234, 1'h0, 6'h00, 5'h10, 5'h14}};
        wr(MCFF_TSADDR_OFF, 32'h1234);
        wr(MCFF_IAMASK_OFF, 32'hffffffff);
        wr(MCFF_GAMASK_OFF, 32'hffff);
        foreach (tab[i]) begin
            wr(MCFF_CMD_OFF, {24'h0, tab[i].m1});
            wr(MCFF_CMD_OFF, {24'h0, tab[i].m2});
            m.send(tab[i].c, 3'h2, {16'h0, tab[i].d}, {47'h0, tab[i].s}, tab[i].f);
            #1;
            v = {st, nz, rd_f, sp, nh};
            chk({27'h0, v & tab[i].k}, {27'h0, tab[i].v});
            if (i == 2) chk({29'h0, sprio}, {29'h0, MCFF_COPYALL_PRIO});
            if (i == 4) begin
                rd(MCFF_RWRPEND_OFF, r);
                chk(r, 32'h1);
                wr(MCFF_RWRPEND_OFF, 32'h1);
                rd(MCFF_RWRPEND_OFF, r);
                chk(r, 32'h0);
            end
        end
        $display("test filter done");
    endtask : t_filter
    task automatic t_stats;
        logic [31:0] a0, b0, c0, a1, b1, c1;
        for (int ls = 0; ls < 2; ls++) begin
            wr(MCFF_CMD_OFF, ls == 1 ? 32'h22 : 32'h20);
            rd(MCFF_TKPASS_OFF, a0);
            rd(MCFF_TKHEARD_OFF, b0);
            rd(MCFF_OTHER_OFF, c0);
            @(posedge pclk);
            {tp, th, os} <= 3'h7;
            @(posedge pclk);
            {tp, th, os} <= 3'h0;
            rd(MCFF_TKPASS_OFF, a1);
            rd(MCFF_TKHEARD_OFF, b1);
            rd(MCFF_OTHER_OFF, c1);
            chk(a1 - a0, {31'h0, ~ls[0]});
            chk(b1 - b0, {31'h0, ~ls[0]});
            chk(c1 - c0, 32'h1);
        end
        $display("test statistics done");
    endtask : t_stats
    task automatic t_delay;
        int n1, n2, n3;
        wr(MCFF_CMD_OFF, 32'h42);
        @(posedge pclk);
        ds <= 1'h1;
        @(posedge pclk);
        ds <= 1'h0;
        meas(n1);
        meas(n2);
        chk(n1 - n2, 32'h8);
        wr(MCFF_CMD_OFF, 32'h40);
        @(posedge pclk);
        ds <= 1'h1;
        @(posedge pclk);
        ds <= 1'h0;
        meas(n3);
        chk(n3, n2);
        $display("test delay done");
    endtask : t_delay
    task automatic stop_test;
        $display("checks=%0d errors=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test
    // Main sequence
    initial begin
        presetn <= 1'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
        t_reset();
        t_cmds();
        t_filter();
        t_stats();
        t_delay();
        stop_test();
    end
    // Watchdog
    initial begin
        #200000;
        n_errors++;
        stop_test();
    end
endmodule : test_mode_command_frame_filter
`default_nettype wire
